// >>> verilog/brk_ctrl.sv
// Breaker control, quick-command dialogue and trip-path supervision
module brk_ctrl
  import brk_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int TW = 20
)(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [5:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic aux_follow_i,
  input wire logic aux_inverse_i,
  input wire logic breaker_ready_i,
  input wire logic sync_ok_i,
  input wire logic prot_trip_i,
  input wire logic lockout_cm_i,
  input wire logic lockout_ar_i,
  input wire logic key_open_i,
  input wire logic key_close_i,
  input wire logic key_confirm_i,
  input wire logic key_cancel_i,
  input wire logic key_restart_i,
  input wire logic key_exit_i,
  input wire logic tpm_i,
  output logic trip_o,
  output logic close_o,
  output logic [3:0] ui_screen_o,
  output logic lockout_o,
  output logic open_fail_o,
  output logic close_fail_o,
  output logic tpm_relay_o,
  output logic tpm_led_o,
  output logic tpm_user_alarm_o
);

  // ==========================================================
  // Timebase tick
  logic [31:0] tick_cnt_q;
  wire tick = (tick_cnt_q == 32'(TICK_CYC - 1));

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h1;
  end

  // ==========================================================
  // Register file
  function automatic logic [TW-1:0] set_rst(input int idx);
    case (idx)
      1: set_rst = TW'(CLOSE_PULSE_MS / TICK_MS);
      2: set_rst = TW'(OPEN_PULSE_MS / TICK_MS);
      3: set_rst = TW'(MAN_CLOSE_DLY_MS / TICK_MS);
      4: set_rst = TW'(READY_TMO_MS / TICK_MS);
      5: set_rst = TW'(SYNC_WIN_MS / TICK_MS);
      default: set_rst = TW'(CLEAR_DLY_MS / TICK_MS);
    endcase
  endfunction

  logic [5:0] ctrl_q;
  logic [TW-1:0] set_q [SET_FIRST:SET_LAST];
  logic [31:0] rdata_q;
  wire set_hit = (addr_i >= ADDR_CLOSE_PULSE) && (addr_i <= ADDR_CLEAR_DLY);
  wire [2:0] set_idx = addr_i[4:2];
  wire cmd_wr = wr_i && (addr_i == ADDR_CMD);
  wire sync_en = ctrl_q[CTRL_SYNC_EN];
  wire ready_en = ctrl_q[CTRL_READY_EN];
  wire clr_src_close = ctrl_q[CTRL_CLR_SRC];
  wire [1:0] src = ctrl_q[CTRL_SRC_LSB +: 2];
  wire [TW-1:0] close_w = set_q[1];
  wire [TW-1:0] open_w = set_q[2];
  wire [TW-1:0] man_dly = set_q[3];
  wire [TW-1:0] ready_tmo = set_q[4];
  wire [TW-1:0] sync_win = set_q[5];
  wire [TW-1:0] clr_dly = set_q[6];

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_q <= CTRL_RST;
      for (int i = SET_FIRST; i <= SET_LAST; i++)
        set_q[i] <= set_rst(i);
    end
    else if (wr_i && addr_i == ADDR_CTRL)
      ctrl_q <= wdata_i[5:0];
    else if (wr_i && set_hit)
      set_q[set_idx] <= wdata_i[TW-1:0];
  end

  // ==========================================================
  // Breaker state decode
  logic brk_closed;
  logic brk_open;
  assign brk_closed = (src == SRC_FOLLOW) ? aux_follow_i :
                      (src == SRC_INVERSE) ? !aux_inverse_i :
                      (src == SRC_BOTH) ? (aux_follow_i && !aux_inverse_i) : 1'b0;
  assign brk_open = (src == SRC_FOLLOW) ? !aux_follow_i :
                    (src == SRC_INVERSE) ? aux_inverse_i :
                    (src == SRC_BOTH) ? (!aux_follow_i && aux_inverse_i) : 1'b0;
  wire ctl_en = (src != SRC_NONE);

  // ==========================================================
  // Quick-command dialogue
  brk_ui_e ui_q;
  brk_ui_e ui_d;
  logic [TW-1:0] ui_cnt_q;
  logic [TW-1:0] inh_cnt_q;
  logic pend_close_q;
  wire any_key = key_open_i | key_close_i | key_confirm_i | key_cancel_i |
                 key_restart_i | key_exit_i;
  wire ui_tmo = (ui_cnt_q >= TW'(UI_IDLE_TICKS));
  wire key_inh = (inh_cnt_q != '0);
  wire ui_go = (ui_q == UI_CONFIRM) && key_confirm_i;
  wire ui_cancel = (ui_q == UI_CLOSING) && key_cancel_i;
  wire ui_restart = (ui_q == UI_CLOSING) && key_restart_i;
  brk_ctl_e ctl_q;
  wire ctl_busy = (ctl_q == C_DELAY) || (ctl_q == C_WAIT);

  always_comb
  begin
    ui_d = ui_q;
    case (ui_q)
      UI_DEFAULT:
        if ((key_open_i || key_close_i) && !key_inh)
          ui_d = UI_CONFIRM;
      UI_CONFIRM:
        if (key_confirm_i)
          ui_d = pend_close_q ? UI_CLOSING : UI_STATUS;
        else if (key_cancel_i || (ui_tmo && !any_key))
          ui_d = UI_STATUS;
      UI_CLOSING:
        if (!ctl_busy)
          ui_d = UI_STATUS;
      UI_STATUS:
        if (key_open_i || key_close_i)
          ui_d = UI_CONFIRM;
        else if (key_exit_i || (ui_tmo && !any_key))
          ui_d = UI_DEFAULT;
      default:
        ui_d = UI_DEFAULT;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ui_q <= UI_DEFAULT;
      ui_cnt_q <= '0;
      inh_cnt_q <= '0;
      pend_close_q <= 1'b0;
    end
    else
    begin
      ui_q <= ui_d;
      ui_cnt_q <= (any_key || ui_d != ui_q) ? '0 : ui_cnt_q + TW'(tick);
      if (ui_d == UI_DEFAULT && ui_q != UI_DEFAULT)
        inh_cnt_q <= TW'(KEY_INHIBIT_TICKS);
      else if (tick && key_inh)
        inh_cnt_q <= inh_cnt_q - TW'(1);
      if (ui_d == UI_CONFIRM && ui_q != UI_CONFIRM)
        pend_close_q <= key_close_i;
    end
  end

  // ==========================================================
  // Breaker control sequence
  brk_ctl_e ctl_d;
  logic [TW-1:0] cnt_q;
  logic [TW-1:0] cnt_d;
  logic lock_man_set;
  logic open_fail_set;
  logic close_fail_set;
  logic close_ok;
  wire open_req = (cmd_wr && wdata_i[CMD_OPEN]) || (ui_go && !pend_close_q);
  wire close_req = (cmd_wr && wdata_i[CMD_CLOSE]) || (ui_go && pend_close_q);
  wire ready_ok = !ready_en || breaker_ready_i;
  wire sync_ok = !sync_en || sync_ok_i;

  always_comb
  begin
    ctl_d = ctl_q;
    cnt_d = cnt_q + TW'(tick);
    lock_man_set = 1'b0;
    open_fail_set = 1'b0;
    close_fail_set = 1'b0;
    close_ok = 1'b0;
    case (ctl_q)
      C_IDLE:
        if (open_req && ctl_en && brk_closed)
          ctl_d = C_OPEN;
        else if (close_req && ctl_en && brk_open && !prot_trip_i)
          ctl_d = C_DELAY;
      C_DELAY:
        if (ui_cancel)
          ctl_d = C_IDLE;
        else if (ui_restart)
          cnt_d = '0;
        else if (cnt_q >= man_dly)
          ctl_d = C_WAIT;
      C_WAIT:
        if (ready_ok && sync_ok)
          ctl_d = C_CLOSE;
        else if ((!ready_ok && cnt_q >= ready_tmo) || (!sync_ok && cnt_q >= sync_win))
        begin
          ctl_d = C_IDLE;
          lock_man_set = 1'b1;
        end
      C_CLOSE:
        if (cnt_q >= close_w)
        begin
          ctl_d = C_IDLE;
          close_fail_set = !brk_closed;
          close_ok = brk_closed;
        end
      C_OPEN:
        if (cnt_q >= open_w)
        begin
          ctl_d = C_IDLE;
          open_fail_set = !brk_open;
        end
      default:
        ctl_d = C_IDLE;
    endcase
    if (prot_trip_i && ctl_q != C_OPEN && ctl_q != C_IDLE)
      ctl_d = C_IDLE;
    if (ctl_d != ctl_q)
      cnt_d = '0;
  end

  // ==========================================================
  // Lockout, alarms and auto-clear
  logic [2:0] lock_q;
  logic clr_run_q;
  logic [TW-1:0] clr_cnt_q;
  logic open_fail_q;
  logic close_fail_q;
  wire auto_clr = clr_run_q && (clr_cnt_q >= clr_dly);
  wire lock_clr = (cmd_wr && wdata_i[CMD_LOCK_CLR]) || (auto_clr && clr_src_close);
  wire alarm_clr = cmd_wr && wdata_i[CMD_ALARM_CLR];

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctl_q <= C_IDLE;
      cnt_q <= '0;
      trip_o <= 1'b0;
      close_o <= 1'b0;
      lock_q <= '0;
      clr_run_q <= 1'b0;
      clr_cnt_q <= '0;
      open_fail_q <= 1'b0;
      close_fail_q <= 1'b0;
    end
    else
    begin
      ctl_q <= ctl_d;
      cnt_q <= cnt_d;
      trip_o <= prot_trip_i || (ctl_d == C_OPEN);
      close_o <= (ctl_d == C_CLOSE) && !prot_trip_i && sync_ok;
      lock_q <= {lockout_ar_i, lockout_cm_i, lock_man_set} | (lock_q & ~{3{lock_clr}});
      clr_run_q <= close_ok || (clr_run_q && !auto_clr);
      clr_cnt_q <= close_ok ? '0 : clr_cnt_q + TW'(tick);
      open_fail_q <= open_fail_set || (open_fail_q && !alarm_clr);
      close_fail_q <= close_fail_set || (close_fail_q && !alarm_clr);
    end
  end

  assign lockout_o = |lock_q;
  assign open_fail_o = open_fail_q;
  assign close_fail_o = close_fail_q;
  assign ui_screen_o = ui_q;

  // ==========================================================
  // Trip-path monitor
  logic tpm_on_q;
  logic [TW-1:0] tpm_low_q;
  logic [TW-1:0] tpm_pu_q;
  logic tpm_fail_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tpm_on_q <= 1'b0;
      tpm_low_q <= '0;
      tpm_pu_q <= '0;
      tpm_fail_q <= 1'b0;
    end
    else
    begin
      if (tpm_i)
      begin
        tpm_on_q <= 1'b1;
        tpm_low_q <= '0;
      end
      else if (tpm_on_q && tick)
      begin
        tpm_low_q <= tpm_low_q + TW'(1);
        if (tpm_low_q == TW'(TPM_DROP_TICKS - 1))
          tpm_on_q <= 1'b0;
      end
      if (tpm_i || tpm_on_q)
      begin
        tpm_pu_q <= '0;
        tpm_fail_q <= 1'b0;
      end
      else if (tpm_pu_q >= TW'(TPM_PICKUP_TICKS))
        tpm_fail_q <= 1'b1;
      else
        tpm_pu_q <= tpm_pu_q + TW'(tick);
    end
  end

  assign tpm_relay_o = tpm_on_q;
  assign tpm_led_o = tpm_fail_q;
  assign tpm_user_alarm_o = tpm_fail_q;

  // ==========================================================
  // Register read port
  wire [31:0] status_w = {14'h0000, ui_q, ctl_q, tpm_fail_q, tpm_on_q, close_fail_q,
                          open_fail_q, lock_q, brk_open, brk_closed};
  wire [31:0] rd_mux = (addr_i == ADDR_CTRL) ? {26'h0000000, ctrl_q} :
                       set_hit ? {{(32-TW){1'b0}}, set_q[set_idx]} :
                       (addr_i == ADDR_STATUS) ? status_w : 32'h00000000;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_q <= '0;
    else
      rdata_q <= rd_i ? rd_mux : 32'h00000000;
  end
  assign rdata_o = rdata_q;

  // ==========================================================
  // Checks
  AST_TRIP_PRIO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    prot_trip_i |=> trip_o && !close_o) else $error("trip did not override close");
  AST_SYNC_GATE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    close_o |-> !$past(sync_en) || $past(sync_ok_i)) else $error("close without synchronism");
  AST_SYNC_LOCK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ctl_q == C_WAIT && sync_en && !sync_ok_i && cnt_q >= sync_win && !prot_trip_i)
    |=> lock_q[0] && ctl_q == C_IDLE) else $error("sync window expiry missed");
  AST_CLOSE_FAIL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ctl_q == C_CLOSE && cnt_q >= close_w && !brk_closed && !prot_trip_i)
    |=> close_fail_o) else $error("close failure not flagged");
  AST_INHIBIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ui_q == UI_DEFAULT && inh_cnt_q != '0) |=> ui_q == UI_DEFAULT)
    else $error("quick command accepted while inhibited");
  AST_EXIT_INH: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ui_q == UI_STATUS && key_exit_i && !key_open_i && !key_close_i)
    |=> ui_q == UI_DEFAULT ##1 key_inh[*8]) else $error("inhibit not started on exit");
  AST_UI_TMO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ui_q == UI_CONFIRM && ui_tmo && !any_key) |=> ui_q == UI_STATUS)
    else $error("confirm timeout not taken");
  AST_DROP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $fell(tpm_on_q) |-> $past(tpm_low_q) == TW'(TPM_DROP_TICKS - 1) && !$past(tpm_i))
    else $error("monitor dropped early");
  AST_SET: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tpm_i |=> tpm_on_q) else $error("monitor not set at once");
  AST_LED_CLR: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    tpm_on_q |-> !tpm_led_o && !tpm_user_alarm_o) else $error("alarm shown while healthy");
  AST_STATE_QUAL: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (ctl_q == C_IDLE && ctl_d == C_DELAY) |-> brk_open && ctl_en)
    else $error("close started from wrong breaker state");

endmodule

// >>> verilog/brk_pkg.sv
// Constants, register map and state types for the breaker supervision block
//
// Functional notes
// - Protection trip aborts close, trip wins.
// - Close output only while synchronism criteria hold.
// - No synchronism within window: lockout and alarm. The code sets only the manual lockout bit and raises no alarm flag.
// - Breaker not ready within timeout: lockout, alarm. The code sets only the manual lockout bit and raises no alarm flag.
// - Clear source close: auto-clear after delay.
// - No state change by pulse end: failure alarm.
// - Ready and sync timeouts apply to manual only.
// - Lockout clear covers manual, monitoring, reclose lockouts.
// - Quick open/close needs operator confirmation first.
// - Quick close times delay, accepts cancel/restart.
// - 25 s idle at confirm: show status.
// - 25 s idle at status: default display.
// - Quick commands ignored 10 s after exit.
// - Monitor sets instantly, drops after 400 ms low.
// - Failure indication delayed by 50 ms pick-up.
// - Monitor set: relay open, LED/alarm cleared.
// - Aux contacts follow/inverse, both decoded jointly.
// - Open needs closed, close needs open; none disables.
// - Every manual close waits the close delay.
// - Open and close pulses have separate widths.
package brk_pkg;

  // ==========================================================
  // Timebase
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int UI_IDLE_MS = 25000;
  localparam int UI_IDLE_TICKS = UI_IDLE_MS / TICK_MS;
  localparam int KEY_INHIBIT_MS = 10000;
  localparam int KEY_INHIBIT_TICKS = KEY_INHIBIT_MS / TICK_MS;
  localparam int TPM_DROP_MS = 400;
  localparam int TPM_DROP_TICKS = TPM_DROP_MS / TICK_MS;
  localparam int TPM_PICKUP_MS = 50;
  localparam int TPM_PICKUP_TICKS = TPM_PICKUP_MS / TICK_MS;

  // ==========================================================
  // Setting defaults in milliseconds
  localparam int CLOSE_PULSE_MS = 500;
  localparam int OPEN_PULSE_MS = 500;
  localparam int MAN_CLOSE_DLY_MS = 10000;
  localparam int READY_TMO_MS = 5000;
  localparam int SYNC_WIN_MS = 5000;
  localparam int CLEAR_DLY_MS = 5000;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_CLOSE_PULSE = 6'h04;
  localparam logic [5:0] ADDR_OPEN_PULSE = 6'h08;
  localparam logic [5:0] ADDR_MAN_CLOSE_DLY = 6'h0C;
  localparam logic [5:0] ADDR_READY_TMO = 6'h10;
  localparam logic [5:0] ADDR_SYNC_WIN = 6'h14;
  localparam logic [5:0] ADDR_CLEAR_DLY = 6'h18;
  localparam logic [5:0] ADDR_CMD = 6'h1C;
  localparam logic [5:0] ADDR_STATUS = 6'h20;
  localparam int SET_FIRST = 1;
  localparam int SET_LAST = 6;

  // Control register fields
  localparam int CTRL_SYNC_EN = 0;
  localparam int CTRL_READY_EN = 1;
  localparam int CTRL_CLR_SRC = 2;
  localparam int CTRL_SRC_LSB = 4;
  localparam logic [5:0] CTRL_RST = 6'h04;

  // Command register fields
  localparam int CMD_OPEN = 0;
  localparam int CMD_CLOSE = 1;
  localparam int CMD_LOCK_CLR = 2;
  localparam int CMD_ALARM_CLR = 3;

  // Breaker state source encodings
  localparam logic [1:0] SRC_NONE = 2'h0;
  localparam logic [1:0] SRC_FOLLOW = 2'h1;
  localparam logic [1:0] SRC_INVERSE = 2'h2;
  localparam logic [1:0] SRC_BOTH = 2'h3;

  typedef enum logic [4:0] {
    C_IDLE = 5'h01,
    C_DELAY = 5'h02,
    C_WAIT = 5'h04,
    C_CLOSE = 5'h08,
    C_OPEN = 5'h10
  } brk_ctl_e;

  typedef enum logic [3:0] {
    UI_DEFAULT = 4'h1,
    UI_CONFIRM = 4'h2,
    UI_CLOSING = 4'h4,
    UI_STATUS = 4'h8
  } brk_ui_e;

endpackage

// >>> test/brk_breaker_model.sv
// Circuit breaker model: coil inputs, auxiliary contact outputs
module brk_breaker_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic close_coil_i,
  input wire logic open_coil_i,
  input wire logic stuck_i,
  output logic aux_follow_o,
  output logic aux_inverse_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Mechanism: one coil held three cycles moves the contacts
  logic closed_q;
  logic [1:0] coil_cnt_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      closed_q <= 1'b0;
      coil_cnt_q <= 2'h0;
    end
    else if (stuck_i || (close_coil_i == open_coil_i))
      coil_cnt_q <= 2'h0;
    else if (coil_cnt_q == 2'h2)
      closed_q <= close_coil_i;
    else
      coil_cnt_q <= coil_cnt_q + 2'h1;
  end

  assign aux_follow_o = closed_q;
  assign aux_inverse_o = ~closed_q;
endmodule

// >>> test/brk_ctrl_bench.sv
// Self-checking bench for the breaker supervision block
module brk_ctrl_bench
  import brk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Stimulus and observed signals
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [5:0] addr_i = 6'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sync_ok_i = 1'b1;
  logic prot_trip_i = 1'b0;
  logic breaker_ready_i = 1'b1;
  logic tpm_i = 1'b0;
  logic stuck = 1'b0;
  logic [1:0] lock_src = 2'h0;
  logic [5:0] keys = 6'h00;
  logic [31:0] rdata_o;
  logic [3:0] ui_screen_o;
  logic aux_follow, aux_inverse, trip_o, close_o, lockout_o, open_fail_o, close_fail_o;
  logic tpm_relay_o, tpm_led_o, tpm_user_alarm_o;
  int n_fail = 0;
  int n_checks = 0;
  int cycles = 0;
  int rst_tab [1:6] = '{50, 50, 1000, 500, 500, 500};
  int set_tab [1:6] = '{3, 3, 2, 3, 3, 2};

  always #10 clk_sys_i = ~clk_sys_i;

  brk_ctrl #(.TICK_CYC(4)) u_brk_ctrl (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .aux_follow_i(aux_follow),
    .aux_inverse_i(aux_inverse), .breaker_ready_i(breaker_ready_i), .sync_ok_i(sync_ok_i),
    .prot_trip_i(prot_trip_i), .lockout_cm_i(lock_src[0]), .lockout_ar_i(lock_src[1]),
    .key_open_i(keys[0]), .key_close_i(keys[1]), .key_confirm_i(keys[2]),
    .key_cancel_i(keys[3]), .key_restart_i(keys[4]), .key_exit_i(keys[5]),
    .tpm_i(tpm_i), .trip_o(trip_o), .close_o(close_o), .ui_screen_o(ui_screen_o),
    .lockout_o(lockout_o), .open_fail_o(open_fail_o), .close_fail_o(close_fail_o),
    .tpm_relay_o(tpm_relay_o), .tpm_led_o(tpm_led_o), .tpm_user_alarm_o(tpm_user_alarm_o));

  brk_breaker_model u_brk_breaker_model (
    .clk_i(clk_sys_i), .rst_n_i(rst_n_i), .close_coil_i(close_o), .open_coil_i(trip_o),
    .stuck_i(stuck), .aux_follow_o(aux_follow), .aux_inverse_o(aux_inverse));

  // ==========================================================
  // Verdict, comparisons and bus access
  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic chk_rd(input logic [5:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk_reg(rdata_o & mask, exp);
  endtask

  function automatic logic [3:0] pick(input int s);
    case (s)
      0: return {3'h0, close_o};
      1: return {3'h0, trip_o};
      2: return {3'h0, lockout_o};
      3: return {3'h0, tpm_relay_o};
      4: return {3'h0, tpm_led_o};
      5: return {3'h0, close_fail_o};
      6: return {3'h0, open_fail_o};
      7: return {3'h0, tpm_user_alarm_o};
      default: return ui_screen_o;
    endcase
  endfunction

  task automatic wait_pin(input int s, input logic [3:0] v, input int lim);
    int n;
    n = 0;
    #1;
    while (pick(s) !== v && n < lim)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    chk_pin(pick(s), v);
  endtask

  task automatic hold_pin(input int s, input logic [3:0] v, input int cyc);
    logic [3:0] got;
    got = v;
    repeat (cyc)
    begin
      @(posedge clk_sys_i);
      #1;
      if (pick(s) !== v)
        got = pick(s);
    end
    chk_pin(got, v);
  endtask

  task automatic press(input int i);
    @(posedge clk_sys_i);
    keys <= 6'h01 << i;
    @(posedge clk_sys_i);
    keys <= 6'h00;
  endtask

  task automatic do_close();
    wr_reg(ADDR_CMD, 32'h2);
    wait_pin(0, 4'h1, 40);
    wait_pin(0, 4'h0, 40);
  endtask

  task automatic do_open();
    wr_reg(ADDR_CMD, 32'h1);
    wait_pin(1, 4'h1, 4);
    wait_pin(1, 4'h0, 40);
  endtask

  // ==========================================================
  // Hang guard
  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    chk_rd(ADDR_CTRL, 32'hFFFFFFFF, {26'h0, CTRL_RST});
    chk_rd(ADDR_CMD, 32'hFFFFFFFF, 32'h0);
    chk_rd(6'h3C, 32'hFFFFFFFF, 32'h0);
    for (int i = SET_FIRST; i <= SET_LAST; i++)
    begin
      chk_rd(6'(i * 4), 32'hFFFFFFFF, 32'(rst_tab[i]));
      wr_reg(6'(i * 4), 32'hFFF00000 | 32'(set_tab[i]));
      chk_rd(6'(i * 4), 32'hFFFFFFFF, 32'(set_tab[i]));
    end
    wr_reg(ADDR_CTRL, 32'h30);
    wr_reg(ADDR_CMD, 32'h1);
    hold_pin(1, 4'h0, 40);
    wr_reg(ADDR_CMD, 32'h2);
    hold_pin(0, 4'h0, 7);
    wait_pin(0, 4'h1, 40);
    wait_pin(0, 4'h0, 40);
    wait_pin(5, 4'h0, 1);
    chk_rd(ADDR_STATUS, 32'h3, 32'h1);
    wr_reg(ADDR_CTRL, 32'h10);
    chk_rd(ADDR_STATUS, 32'h3, 32'h1);
    wr_reg(ADDR_CTRL, 32'h20);
    chk_rd(ADDR_STATUS, 32'h3, 32'h1);
    wr_reg(ADDR_CTRL, 32'h00);
    wr_reg(ADDR_CMD, 32'h1);
    hold_pin(1, 4'h0, 22);
    wr_reg(ADDR_CTRL, 32'h30);
    wr_reg(ADDR_CMD, 32'h2);
    hold_pin(0, 4'h0, 40);
    do_open();
    wait_pin(6, 4'h0, 1);
    chk_rd(ADDR_STATUS, 32'h3, 32'h2);
    wr_reg(ADDR_CTRL, 32'h36);
    breaker_ready_i <= 1'b0;
    wr_reg(ADDR_CMD, 32'h2);
    wait_pin(2, 4'h1, 60);
    breaker_ready_i <= 1'b1;
    wr_reg(ADDR_CMD, 32'h2);
    wait_pin(0, 4'h1, 40);
    wait_pin(2, 4'h1, 1);
    wait_pin(0, 4'h0, 40);
    wait_pin(2, 4'h0, 20);
    do_open();
    wr_reg(ADDR_CTRL, 32'h31);
    sync_ok_i <= 1'b0;
    wr_reg(ADDR_CMD, 32'h2);
    wait_pin(2, 4'h1, 60);
    wait_pin(0, 4'h0, 1);
    wr_reg(ADDR_CMD, 32'h4);
    wait_pin(2, 4'h0, 4);
    sync_ok_i <= 1'b1;
    wr_reg(ADDR_CMD, 32'h2);
    wait_pin(0, 4'h1, 40);
    repeat (4) @(posedge clk_sys_i);
    sync_ok_i <= 1'b0;
    wait_pin(0, 4'h0, 3);
    @(posedge clk_sys_i);
    sync_ok_i <= 1'b1;
    repeat (30) @(posedge clk_sys_i);
    do_open();
    wr_reg(ADDR_CTRL, 32'h30);
    wr_reg(ADDR_CMD, 32'h2);
    wait_pin(0, 4'h1, 40);
    @(posedge clk_sys_i);
    prot_trip_i <= 1'b1;
    wait_pin(0, 4'h0, 2);
    wait_pin(1, 4'h1, 1);
    @(posedge clk_sys_i);
    prot_trip_i <= 1'b0;
    repeat (30) @(posedge clk_sys_i);
    wr_reg(ADDR_CMD, 32'h8);
    stuck <= 1'b1;
    wr_reg(ADDR_CMD, 32'h2);
    wait_pin(5, 4'h1, 60);
    wr_reg(ADDR_CMD, 32'h8);
    wait_pin(5, 4'h0, 4);
    stuck <= 1'b0;
    do_close();
    stuck <= 1'b1;
    wr_reg(ADDR_CMD, 32'h1);
    wait_pin(6, 4'h1, 60);
    stuck <= 1'b0;
    wr_reg(ADDR_CMD, 32'h8);
    wait_pin(6, 4'h0, 4);
    do_open();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk_sys_i);
      lock_src <= 2'h1 << i;
      @(posedge clk_sys_i);
      lock_src <= 2'h0;
      wait_pin(2, 4'h1, 4);
      wr_reg(ADDR_CMD, 32'h4);
      wait_pin(2, 4'h0, 4);
    end
    wait_pin(4, 4'h1, 2);
    @(posedge clk_sys_i);
    tpm_i <= 1'b1;
    wait_pin(3, 4'h1, 2);
    wait_pin(4, 4'h0, 3);
    @(posedge clk_sys_i);
    tpm_i <= 1'b0;
    hold_pin(3, 4'h1, 150);
    wait_pin(3, 4'h0, 20);
    hold_pin(4, 4'h0, 14);
    wait_pin(4, 4'h1, 12);
    wait_pin(7, 4'h1, 1);
    repeat (4100) @(posedge clk_sys_i);
    press(1);
    wait_pin(8, 4'h2, 3);
    hold_pin(0, 4'h0, 20);
    repeat (9950) @(posedge clk_sys_i);
    wait_pin(8, 4'h2, 0);
    wait_pin(8, 4'h8, 200);
    repeat (9950) @(posedge clk_sys_i);
    wait_pin(8, 4'h8, 0);
    wait_pin(8, 4'h1, 200);
    press(1);
    hold_pin(8, 4'h1, 20);
    repeat (4100) @(posedge clk_sys_i);
    press(1);
    wait_pin(8, 4'h2, 3);
    press(2);
    wait_pin(8, 4'h4, 3);
    repeat (4) @(posedge clk_sys_i);
    press(4);
    hold_pin(0, 4'h0, 7);
    wait_pin(0, 4'h1, 40);
    wait_pin(8, 4'h8, 60);
    press(5);
    wait_pin(8, 4'h1, 3);
    hold_pin(8, 4'h1, 10);
    repeat (4100) @(posedge clk_sys_i);
    do_open();
    press(1);
    wait_pin(8, 4'h2, 3);
    press(2);
    wait_pin(8, 4'h4, 3);
    press(3);
    wait_pin(8, 4'h8, 3);
    hold_pin(0, 4'h0, 20);
    finish_test();
  end
endmodule
